// ---- common/cefb_pkg.sv ----
// Constants shared by the charger event flag bank
package cefb_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TIMER_AND_DONE   = 8'h24;
    localparam logic [7:0] OFF_TEMP_AND_SOURCE  = 8'h25;
    localparam logic [7:0] OFF_PROTECTION_ENTRY = 8'h26;

    // ------------------------------------------------------------------
    // Reset values and implemented-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAG_RESET     = 8'h00;
    localparam logic [7:0] TD_USED_BITS   = 8'h7F;
    localparam logic [7:0] TS_USED_BITS   = 8'h1F;
    localparam logic [7:0] PE_USED_BITS   = 8'hFF;

    // ------------------------------------------------------------------
    // Field positions, timer-and-done register
    // ------------------------------------------------------------------
    localparam int B_PORT_DETECT_DONE = 6;
    localparam int B_CONV_DONE        = 5;
    localparam int B_SYSTEM_FLOOR     = 4;
    localparam int B_FAST_TIMEOUT     = 3;
    localparam int B_TRICKLE_TIMEOUT  = 2;
    localparam int B_PRECHARGE_TMO    = 1;
    localparam int B_TOPOFF_TIMEOUT   = 0;

    // ------------------------------------------------------------------
    // Field positions, temperature-and-source register
    // ------------------------------------------------------------------
    localparam int B_BATT_LOW_SOURCE  = 4;
    localparam int B_COLD_ZONE        = 3;
    localparam int B_COOL_ZONE        = 2;
    localparam int B_WARM_ZONE        = 1;
    localparam int B_HOT_ZONE         = 0;

    // ------------------------------------------------------------------
    // Field positions, protection entry register
    // ------------------------------------------------------------------
    localparam int B_BATT_CUR_REG     = 7;
    localparam int B_BUS_OVP          = 6;
    localparam int B_BATT_OVP         = 5;
    localparam int B_BUS_OCP          = 4;
    localparam int B_DISCHARGE_OCP    = 3;
    localparam int B_CONV_OCP         = 2;
    localparam int B_IN2_OVP          = 1;
    localparam int B_IN1_OVP          = 0;

    // ------------------------------------------------------------------
    // Index of each raw event input in the event vector
    // ------------------------------------------------------------------
    localparam int EV_PORT_DONE   = 0;
    localparam int EV_CONV_DONE   = 1;
    localparam int EV_SYS_FLOOR   = 2;
    localparam int EV_FAST_TMO    = 3;
    localparam int EV_TRICKLE_TMO = 4;
    localparam int EV_PRE_TMO     = 5;
    localparam int EV_TOPOFF_TMO  = 6;
    localparam int EV_BATT_LOW    = 7;
    localparam int EV_COLD        = 8;
    localparam int EV_COOL        = 9;
    localparam int EV_WARM        = 10;
    localparam int EV_HOT         = 11;
    localparam int EV_CUR_REG     = 12;
    localparam int EV_BUS_OVP     = 13;
    localparam int EV_BATT_OVP    = 14;
    localparam int EV_BUS_OCP     = 15;
    localparam int EV_DSG_OCP     = 16;
    localparam int EV_CONV_OCP    = 17;
    localparam int EV_IN2_OVP     = 18;
    localparam int EV_IN1_OVP     = 19;
    localparam int EV_COUNT       = 20;

endpackage

// ---- rtl/cefb_event_detect.sv ----
// Two-stage synchroniser and edge detector for the raw event levels
`timescale 1ns/1ps
module cefb_event_detect
(
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic [cefb_pkg::EV_COUNT-1:0] raw,
    output logic      [cefb_pkg::EV_COUNT-1:0] rise,
    output logic      [cefb_pkg::EV_COUNT-1:0] fall
);
    import cefb_pkg::*;

    typedef struct packed
    {
        logic [EV_COUNT-1:0] meta;
        logic [EV_COUNT-1:0] sync;
        logic [EV_COUNT-1:0] prev;
    } cefb_sync_t;

    cefb_sync_t sync_q;
    cefb_sync_t sync_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        sync_d      = sync_q;
        sync_d.meta = raw;
        sync_d.sync = sync_q.meta;
        sync_d.prev = sync_q.sync;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync_q <= '0;
        end
        else
        begin
            sync_q <= sync_d;
        end
    end

    // ------------------------------------------------------------------
    // Edges, one cycle each
    // ------------------------------------------------------------------
    assign rise = sync_q.sync & ~sync_q.prev;
    assign fall = ~sync_q.sync & sync_q.prev;

endmodule

// ---- rtl/cefb_flag_bank.sv ----
// Charger event flag bank: three clear-on-read event flag registers
//
// Contract
// - Port detect flag stays 0 until detection completes, then sets.
// - Conversion done flag sets on completion, only in one-shot mode.
// - System floor flag sets on entering or leaving minimum system voltage.
// - Fast charge timeout flag sets on rising edge of expiry.
// - Trickle timeout flag sets on rising edge of expiry.
// - Precharge timeout flag sets on rising edge of expiry.
// - Top-off timeout flag sets on rising edge of expiry.
// - Battery too low for source mode flag sets when voltage falls below.
// - Cold zone flag sets when thermistor crosses cold threshold.
// - Cool zone flag sets when thermistor crosses cool threshold.
// - Warm zone flag sets when thermistor crosses warm threshold.
// - Hot zone flag sets when thermistor crosses hot threshold.
// - Battery current regulation flag sets on entry or exit.
// - Input bus overvoltage flag sets on protection entry.
// - Battery overvoltage flag sets on protection entry.
// - Input bus overcurrent flag sets on protection entry.
// - Discharge overcurrent flag sets on protection entry.
// - Converter overcurrent flag sets on protection entry.
// - Second and first input overvoltage flags set on protection entry.
// - All flags clear at reset; reserved bits always read zero.
// - Mask bit 1 blocks an event's interrupt pulse, 0 passes it.
`timescale 1ns/1ps
module cefb_flag_bank
(
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          port_detect_done,
    input  wire logic                          conv_done,
    input  wire logic                          conv_one_shot,
    input  wire logic                          system_floor_active,
    input  wire logic                          fast_charge_expired,
    input  wire logic                          trickle_expired,
    input  wire logic                          precharge_expired,
    input  wire logic                          topoff_expired,
    input  wire logic                          battery_below_source_min,
    input  wire logic                          cold_zone,
    input  wire logic                          cool_zone,
    input  wire logic                          warm_zone,
    input  wire logic                          hot_zone,
    input  wire logic                          battery_current_regulation,
    input  wire logic                          input_bus_overvoltage,
    input  wire logic                          battery_overvoltage,
    input  wire logic                          input_bus_overcurrent,
    input  wire logic                          discharge_overcurrent,
    input  wire logic                          converter_overcurrent,
    input  wire logic                          second_input_overvoltage,
    input  wire logic                          first_input_overvoltage,
    input  wire logic [7:0]                    mask_timer_and_done,
    input  wire logic [7:0]                    mask_temp_and_source,
    input  wire logic [7:0]                    mask_protection_entry,
    input  wire logic                          rd_en,
    input  wire logic [7:0]                    rd_addr,
    output logic      [7:0]                    rd_data,
    output logic                               irq_pulse
);
    import cefb_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] td;
        logic [7:0] ts;
        logic [7:0] pe;
        logic [7:0] rdata;
        logic       irq;
    } cefb_state_t;

    cefb_state_t         state_q;
    cefb_state_t         state_d;
    logic [EV_COUNT-1:0] raw_w;
    logic [EV_COUNT-1:0] rise_w;
    logic [EV_COUNT-1:0] fall_w;
    logic [7:0]          ev_td;
    logic [7:0]          ev_ts;
    logic [7:0]          ev_pe;
    logic                rd_td;
    logic                rd_ts;
    logic                rd_pe;

    // Either edge of a level counts as a crossing
    function automatic logic changed(input logic [EV_COUNT-1:0] r,
                                     input logic [EV_COUNT-1:0] f,
                                     input int                  idx);
        changed = r[idx] | f[idx];
    endfunction

    // ------------------------------------------------------------------
    // Synchronise raw levels and find edges
    // ------------------------------------------------------------------
    // Packed in event index order, port detect in bit 0
    assign raw_w = {first_input_overvoltage, second_input_overvoltage, converter_overcurrent,
                    discharge_overcurrent, input_bus_overcurrent, battery_overvoltage,
                    input_bus_overvoltage, battery_current_regulation, hot_zone, warm_zone,
                    cool_zone, cold_zone, battery_below_source_min, topoff_expired,
                    precharge_expired, trickle_expired, fast_charge_expired,
                    system_floor_active, conv_done, port_detect_done};

    cefb_event_detect u_detect
    (
        .clock (clock),
        .rst   (rst),
        .raw   (raw_w),
        .rise  (rise_w),
        .fall  (fall_w)
    );

    // ------------------------------------------------------------------
    // Event to flag bit mapping
    // ------------------------------------------------------------------
    always_comb
    begin
        ev_td = 8'h00;
        ev_ts = 8'h00;
        ev_pe = 8'h00;
        ev_td[B_PORT_DETECT_DONE] = rise_w[EV_PORT_DONE];
        ev_td[B_CONV_DONE]        = rise_w[EV_CONV_DONE] & conv_one_shot;
        ev_td[B_SYSTEM_FLOOR]     = changed(rise_w, fall_w, EV_SYS_FLOOR);
        ev_td[B_FAST_TIMEOUT]     = rise_w[EV_FAST_TMO];
        ev_td[B_TRICKLE_TIMEOUT]  = rise_w[EV_TRICKLE_TMO];
        ev_td[B_PRECHARGE_TMO]    = rise_w[EV_PRE_TMO];
        ev_td[B_TOPOFF_TIMEOUT]   = rise_w[EV_TOPOFF_TMO];
        ev_ts[B_BATT_LOW_SOURCE]  = rise_w[EV_BATT_LOW];
        ev_ts[B_COLD_ZONE]        = changed(rise_w, fall_w, EV_COLD);
        ev_ts[B_COOL_ZONE]        = changed(rise_w, fall_w, EV_COOL);
        ev_ts[B_WARM_ZONE]        = changed(rise_w, fall_w, EV_WARM);
        ev_ts[B_HOT_ZONE]         = changed(rise_w, fall_w, EV_HOT);
        ev_pe[B_BATT_CUR_REG]     = changed(rise_w, fall_w, EV_CUR_REG);
        ev_pe[B_BUS_OVP]          = rise_w[EV_BUS_OVP];
        ev_pe[B_BATT_OVP]         = rise_w[EV_BATT_OVP];
        ev_pe[B_BUS_OCP]          = rise_w[EV_BUS_OCP];
        ev_pe[B_DISCHARGE_OCP]    = rise_w[EV_DSG_OCP];
        ev_pe[B_CONV_OCP]         = rise_w[EV_CONV_OCP];
        ev_pe[B_IN2_OVP]          = rise_w[EV_IN2_OVP];
        ev_pe[B_IN1_OVP]          = rise_w[EV_IN1_OVP];
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    assign rd_td = rd_en && (rd_addr == OFF_TIMER_AND_DONE);
    assign rd_ts = rd_en && (rd_addr == OFF_TEMP_AND_SOURCE);
    assign rd_pe = rd_en && (rd_addr == OFF_PROTECTION_ENTRY);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        // Clear on read, with a same-cycle event still landing
        state_d.td = ((rd_td ? 8'h00 : state_q.td) | ev_td) & TD_USED_BITS;
        state_d.ts = ((rd_ts ? 8'h00 : state_q.ts) | ev_ts) & TS_USED_BITS;
        state_d.pe = ((rd_pe ? 8'h00 : state_q.pe) | ev_pe) & PE_USED_BITS;
        if (rd_en)
        begin
            case (rd_addr)
                OFF_TIMER_AND_DONE:   state_d.rdata = state_q.td;
                OFF_TEMP_AND_SOURCE:  state_d.rdata = state_q.ts;
                OFF_PROTECTION_ENTRY: state_d.rdata = state_q.pe;
                default:              state_d.rdata = 8'h00;
            endcase
        end
        state_d.irq = |(ev_td & ~mask_timer_and_done)
                    | |(ev_ts & ~mask_temp_and_source)
                    | |(ev_pe & ~mask_protection_entry);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= '{td: FLAG_RESET, ts: FLAG_RESET, pe: FLAG_RESET,
                         rdata: FLAG_RESET, irq: 1'b0};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign rd_data   = state_q.rdata;
    assign irq_pulse = state_q.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_port_done;
        @(posedge clock) disable iff (rst)
        rise_w[EV_PORT_DONE] |=> state_q.td[B_PORT_DETECT_DONE];
    endproperty
    a_port_done: assert property (p_port_done)
        else $error("port detect flag not set on completion");

    property p_conv_one_shot;
        @(posedge clock) disable iff (rst)
        $rose(state_q.td[B_CONV_DONE]) |-> $past(conv_one_shot) && $past(rise_w[EV_CONV_DONE]);
    endproperty
    a_conv_one_shot: assert property (p_conv_one_shot)
        else $error("conversion flag set outside one-shot completion");

    property p_floor_exit;
        @(posedge clock) disable iff (rst)
        fall_w[EV_SYS_FLOOR] |=> state_q.td[B_SYSTEM_FLOOR];
    endproperty
    a_floor_exit: assert property (p_floor_exit)
        else $error("system floor flag missed regulation exit");

    property p_fast_tmo;
        @(posedge clock) disable iff (rst)
        rise_w[EV_FAST_TMO] |=> state_q.td[B_FAST_TIMEOUT];
    endproperty
    a_fast_tmo: assert property (p_fast_tmo)
        else $error("fast charge timeout flag missed");
    property p_trickle_tmo;
        @(posedge clock) disable iff (rst)
        rise_w[EV_TRICKLE_TMO] |=> state_q.td[B_TRICKLE_TIMEOUT];
    endproperty
    a_trickle_tmo: assert property (p_trickle_tmo)
        else $error("trickle timeout flag missed");
    property p_pre_tmo;
        @(posedge clock) disable iff (rst)
        rise_w[EV_PRE_TMO] |=> state_q.td[B_PRECHARGE_TMO];
    endproperty
    a_pre_tmo: assert property (p_pre_tmo)
        else $error("precharge timeout flag missed");
    property p_topoff_tmo;
        @(posedge clock) disable iff (rst)
        rise_w[EV_TOPOFF_TMO] |=> state_q.td[B_TOPOFF_TIMEOUT];
    endproperty
    a_topoff_tmo: assert property (p_topoff_tmo)
        else $error("top-off timeout flag missed");

    property p_batt_low;
        @(posedge clock) disable iff (rst)
        rise_w[EV_BATT_LOW] |=> state_q.ts[B_BATT_LOW_SOURCE];
    endproperty
    a_batt_low: assert property (p_batt_low)
        else $error("battery low for source flag missed");

    property p_cold;
        @(posedge clock) disable iff (rst)
        fall_w[EV_COLD] |=> state_q.ts[B_COLD_ZONE];
    endproperty
    a_cold: assert property (p_cold)
        else $error("cold zone crossing missed");
    property p_cool;
        @(posedge clock) disable iff (rst)
        rise_w[EV_COOL] |=> state_q.ts[B_COOL_ZONE];
    endproperty
    a_cool: assert property (p_cool)
        else $error("cool zone crossing missed");
    property p_warm;
        @(posedge clock) disable iff (rst)
        fall_w[EV_WARM] |=> state_q.ts[B_WARM_ZONE];
    endproperty
    a_warm: assert property (p_warm)
        else $error("warm zone crossing missed");
    property p_hot;
        @(posedge clock) disable iff (rst)
        rise_w[EV_HOT] |=> state_q.ts[B_HOT_ZONE];
    endproperty
    a_hot: assert property (p_hot)
        else $error("hot zone crossing missed");

    property p_cur_reg;
        @(posedge clock) disable iff (rst)
        fall_w[EV_CUR_REG] |=> state_q.pe[B_BATT_CUR_REG];
    endproperty
    a_cur_reg: assert property (p_cur_reg)
        else $error("battery current regulation exit missed");

    property p_bus_ovp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_BUS_OVP] |=> state_q.pe[B_BUS_OVP];
    endproperty
    a_bus_ovp: assert property (p_bus_ovp)
        else $error("input bus overvoltage flag missed");
    property p_batt_ovp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_BATT_OVP] |=> state_q.pe[B_BATT_OVP];
    endproperty
    a_batt_ovp: assert property (p_batt_ovp)
        else $error("battery overvoltage flag missed");
    property p_bus_ocp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_BUS_OCP] |=> state_q.pe[B_BUS_OCP];
    endproperty
    a_bus_ocp: assert property (p_bus_ocp)
        else $error("input bus overcurrent flag missed");
    property p_dsg_ocp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_DSG_OCP] |=> state_q.pe[B_DISCHARGE_OCP];
    endproperty
    a_dsg_ocp: assert property (p_dsg_ocp)
        else $error("discharge overcurrent flag missed");
    property p_conv_ocp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_CONV_OCP] |=> state_q.pe[B_CONV_OCP];
    endproperty
    a_conv_ocp: assert property (p_conv_ocp)
        else $error("converter overcurrent flag missed");
    property p_in2_ovp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_IN2_OVP] |=> state_q.pe[B_IN2_OVP];
    endproperty
    a_in2_ovp: assert property (p_in2_ovp)
        else $error("second input overvoltage flag missed");
    property p_in1_ovp;
        @(posedge clock) disable iff (rst)
        rise_w[EV_IN1_OVP] |=> state_q.pe[B_IN1_OVP];
    endproperty
    a_in1_ovp: assert property (p_in1_ovp)
        else $error("first input overvoltage flag missed");

    property p_reserved_zero;
        @(posedge clock) disable iff (rst)
        rd_en && (rd_addr == OFF_TEMP_AND_SOURCE) |=> rd_data[7:5] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_mask_pass;
        @(posedge clock) disable iff (rst)
        (|(ev_td & ~mask_timer_and_done)) || (|(ev_ts & ~mask_temp_and_source))
            || (|(ev_pe & ~mask_protection_entry)) |=> irq_pulse;
    endproperty
    a_mask_pass: assert property (p_mask_pass)
        else $error("unmasked event gave no pulse");

    property p_mask_block;
        @(posedge clock) disable iff (rst)
        (ev_td & ~mask_timer_and_done) == 8'h00 && (ev_ts & ~mask_temp_and_source) == 8'h00
            && (ev_pe & ~mask_protection_entry) == 8'h00 |=> !irq_pulse;
    endproperty
    a_mask_block: assert property (p_mask_block)
        else $error("masked event produced a pulse");

    property p_sticky;
        @(posedge clock) disable iff (rst)
        state_q.td[B_FAST_TIMEOUT] && !rd_td |=> state_q.td[B_FAST_TIMEOUT];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a read");

    property p_read_clear;
        @(posedge clock) disable iff (rst)
        rd_pe && !ev_pe[B_BUS_OVP] |=> !state_q.pe[B_BUS_OVP]
            && rd_data[B_BUS_OVP] == $past(state_q.pe[B_BUS_OVP]);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read did not return and clear the flag");

    property p_set_wins;
        @(posedge clock) disable iff (rst)
        rd_ts && ev_ts[B_COOL_ZONE] |=> state_q.ts[B_COOL_ZONE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during read");

endmodule

// ---- verification/cefb_host_model.sv ----
// Host controller model issuing register reads
`timescale 1ns/1ps
module cefb_host_model
(
    input  wire logic       clock,
    output logic            rd_en,
    output logic      [7:0] rd_addr,
    input  wire logic [7:0] rd_data
);
    initial
    begin
        rd_en   = 1'b0;
        rd_addr = 8'h00;
    end

    // One-cycle strobe; address scrambled once released
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        rd_en   = 1'b1;
        rd_addr = a;
        @(negedge clock);
        rd_en   = 1'b0;
        rd_addr = ~a;
        d       = rd_data;
    endtask
endmodule

// ---- verification/cefb_flag_bank_tb_top.sv ----
// Testbench for the charger event flag bank
`timescale 1ns/1ps
module cefb_flag_bank_tb_top;
    import cefb_pkg::*;
    localparam logic [EV_COUNT-1:0] BOTH_EDGES = 20'h01F04;
    logic                clock    = 1'b0;
    logic                rst      = 1'b1;
    logic [EV_COUNT-1:0] ev       = '0;
    logic                one_shot = 1'b0;
    logic [7:0]          mask     = 8'h00;
    logic                rd_en;
    logic [7:0]          rd_addr;
    logic [7:0]          rd_data;
    logic                irq_pulse;
    logic [7:0]          got;
    logic [7:0]          a;
    logic [7:0]          b;
    int                  err_total = 0;
    int                  compares  = 0;
    int                  irq_cnt   = 0;
    int                  n0;

    always #10 clock = ~clock;

    always @(posedge clock)
        if (irq_pulse === 1'b1)
            irq_cnt <= irq_cnt + 1;

    cefb_flag_bank dut
    (
        .clock(clock), .rst(rst), .port_detect_done(ev[0]), .conv_done(ev[1]),
        .conv_one_shot(one_shot), .system_floor_active(ev[2]), .fast_charge_expired(ev[3]),
        .trickle_expired(ev[4]), .precharge_expired(ev[5]), .topoff_expired(ev[6]),
        .battery_below_source_min(ev[7]), .cold_zone(ev[8]), .cool_zone(ev[9]),
        .warm_zone(ev[10]), .hot_zone(ev[11]), .battery_current_regulation(ev[12]),
        .input_bus_overvoltage(ev[13]), .battery_overvoltage(ev[14]),
        .input_bus_overcurrent(ev[15]), .discharge_overcurrent(ev[16]),
        .converter_overcurrent(ev[17]), .second_input_overvoltage(ev[18]),
        .first_input_overvoltage(ev[19]), .mask_timer_and_done(mask),
        .mask_temp_and_source(mask), .mask_protection_entry(mask), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .irq_pulse(irq_pulse)
    );

    cefb_host_model host
    (
        .clock(clock), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data)
    );

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic check(input logic [7:0] addr, input logic [7:0] e);
        host.rd(addr, got);
        cmp8(got, e);
    endtask

    task automatic final_report();
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_total++;
        final_report();
    end

    initial
    begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check(OFF_TIMER_AND_DONE, FLAG_RESET);
        check(OFF_TEMP_AND_SOURCE, FLAG_RESET);
        check(OFF_PROTECTION_ENTRY, FLAG_RESET);
        check(8'h27, 8'h00);
        ev[EV_CONV_DONE] = 1'b1;
        repeat (5) @(negedge clock);
        check(OFF_TIMER_AND_DONE, 8'h00);
        ev[EV_CONV_DONE] = 1'b0;
        one_shot = 1'b1;
        for (int i = 0; i < EV_COUNT; i++)
        begin
            a = (i < 7) ? OFF_TIMER_AND_DONE : (i < 12) ? OFF_TEMP_AND_SOURCE
                                                         : OFF_PROTECTION_ENTRY;
            b = 8'h01 << ((i < 7) ? 6 - i : (i < 12) ? 11 - i : 19 - i);
            n0 = irq_cnt;
            @(negedge clock);
            ev[i] = 1'b1;
            repeat (5) @(negedge clock);
            cmp8(8'(irq_cnt - n0), 8'h01);
            check(a, b);
            check(a, 8'h00);
            ev[i] = 1'b0;
            repeat (5) @(negedge clock);
            check(a, BOTH_EDGES[i] ? b : 8'h00);
            cmp8(8'(irq_cnt - n0), BOTH_EDGES[i] ? 8'h02 : 8'h01);
        end
        mask = 8'hFF;
        n0 = irq_cnt;
        ev[EV_TOPOFF_TMO] = 1'b1;
        repeat (5) @(negedge clock);
        ev[EV_TOPOFF_TMO] = 1'b0;
        repeat (5) @(negedge clock);
        cmp8(8'(irq_cnt - n0), 8'h00);
        check(OFF_TIMER_AND_DONE, 8'h01);
        // Event edge lands in the very cycle of the read
        ev[EV_COOL] = 1'b1;
        @(negedge clock);
        host.rd(OFF_TEMP_AND_SOURCE, got);
        cmp8(got, 8'h00);
        check(OFF_TEMP_AND_SOURCE, 8'h04);
        // Leave a flag set, then reset in mid-run
        ev[EV_COOL] = 1'b0;
        repeat (5) @(negedge clock);
        rst = 1'b1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check(OFF_TEMP_AND_SOURCE, FLAG_RESET);
        final_report();
    end
endmodule
